// ### ptcd_target.sv
`timescale 1ns/1ps

// Functional notes
// - bus latency wish register is eight bits, read-only, always zero.
// - configuration access claimed only with config command and select input high.
// - command code a is configuration read, b is configuration write.
// - on reads all four byte drivers enable with device select and controls.
// - target ready follows device select by two clock cycles plus any local side wait.
// - word moves when both ready lines are low; reads drive internal data.
// - stop asserted together with target ready, forcing a disconnect.
// - controls driven high one cycle after the transfer, then released.
// - configuration write matches read but never enables the data drivers.
// - address and command latched on first edge with frame low.
// - dma and local accesses share sequence; local ones wait for local side.
// - dma register reads use the configuration read timing.
// - io window accesses are whole 32-bit words.
// - lower half of the 1M window is dma registers, upper half local.
// - dma registers clear to zero on bus reset.
// - io window base is a writable 12-bit field in bits 31 to 20.

module ptcd_target (
    // clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // bus inputs
    input wire logic FRAME_N,
    input wire logic IRDY_N,
    input wire logic IDSEL,
    input wire logic [31:0] AD_IN,
    input wire logic [3:0] CBE_N,
    // bus outputs
    output logic [31:0] AD_OUT,
    output logic [3:0] AD_OE,
    output logic DEVSEL_N,
    output logic TRDY_N,
    output logic STOP_N,
    output logic TAR_OE,
    // local side
    output logic [16:0] LOC_ADDR,
    output logic [31:0] LOC_WDATA,
    output logic LOC_RD,
    output logic LOC_WR,
    input wire logic [31:0] LOC_RDATA,
    input wire logic LOC_ACK,
    // register contents
    output logic [11:0] IO_WINDOW_BASE,
    output logic [31:0] TRANSFER_COUNT_CONTROL_STATUS,
    output logic [31:0] COMMAND_ENABLE_SELECT,
    output logic [31:0] TRANSFER_ADDRESS_COUNTER
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic frame_m;
    logic frame_s;
    logic irdy_m;
    logic irdy_s;
    logic idsel_m;
    logic idsel_s;
    logic [31:0] ad_m;
    logic [31:0] ad_s;
    logic [3:0] cbe_m;
    logic [3:0] cbe_s;

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            frame_m <= 1'b1;
            frame_s <= 1'b1;
            irdy_m <= 1'b1;
            irdy_s <= 1'b1;
            idsel_m <= 1'b0;
            idsel_s <= 1'b0;
            ad_m <= 32'h0000_0000;
            ad_s <= 32'h0000_0000;
            cbe_m <= 4'hf;
            cbe_s <= 4'hf;
        end else begin
            frame_m <= FRAME_N;
            frame_s <= frame_m;
            irdy_m <= IRDY_N;
            irdy_s <= irdy_m;
            idsel_m <= IDSEL;
            idsel_s <= idsel_m;
            ad_m <= AD_IN;
            ad_s <= ad_m;
            cbe_m <= CBE_N;
            cbe_s <= cbe_m;
        end
    end

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic is_cfg_cmd(input logic [3:0] cmd);
        return (cmd == ptcd_pkg::CMD_CFG_READ) || (cmd == ptcd_pkg::CMD_CFG_WRITE);
    endfunction

    function automatic logic is_io_cmd(input logic [3:0] cmd);
        return (cmd == ptcd_pkg::CMD_IO_READ) || (cmd == ptcd_pkg::CMD_IO_WRITE);
    endfunction

    function automatic logic [7:0] cfg_dword(input logic [31:0] addr);
        return {addr[7:2], 2'h0};
    endfunction

    function automatic logic is_base_reg(input logic [31:0] addr);
        return cfg_dword(addr) == ptcd_pkg::CFG_IO_WINDOW_BASE;
    endfunction

    function automatic logic is_lat_reg(input logic [31:0] addr);
        return cfg_dword(addr) == {ptcd_pkg::CFG_BUS_LATENCY_WISH[7:2], 2'h0};
    endfunction

    function automatic logic selects(input ptcd_pkg::ptcd_state_t st);
        return st inside {ptcd_pkg::ST_DEVSEL, ptcd_pkg::ST_WAIT, ptcd_pkg::ST_DATA};
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ptcd_pkg::ptcd_state_t state;
    ptcd_pkg::ptcd_state_t next_state;
    ptcd_pkg::ptcd_addr_t cap;
    ptcd_pkg::ptcd_addr_t next_cap;
    ptcd_pkg::ptcd_dma_wr_t dma_wr;
    logic frame_prev;
    logic is_read;
    logic next_is_read;
    logic is_ext;
    logic next_is_ext;
    logic loc_busy;
    logic next_loc_busy;
    logic [31:0] next_ad_out;
    logic [3:0] next_ad_oe;
    logic next_devsel_n;
    logic next_trdy_n;
    logic next_stop_n;
    logic next_tar_oe;
    logic [16:0] next_loc_addr;
    logic [31:0] next_loc_wdata;
    logic next_loc_rd;
    logic next_loc_wr;
    logic [11:0] next_base;
    logic [31:0] dma_rdata;
    logic [31:0] cfg_rdata;
    logic cfg_hit;
    logic io_hit;

    ptcd_dma_regs u_dma_regs (
        .clk(CLK),
        .nrst(NRST),
        .wr(dma_wr),
        .rd_offset(cap.addr[19:0]),
        .rd_data(dma_rdata),
        .tccs(TRANSFER_COUNT_CONTROL_STATUS),
        .cesr(COMMAND_ENABLE_SELECT),
        .acr(TRANSFER_ADDRESS_COUNTER)
    );

    // ------------------------------------------------------------
    // configuration read data
    // ------------------------------------------------------------
    always_comb begin
        cfg_rdata = 32'h0000_0000;
        if (is_base_reg(cap.addr)) begin
            cfg_rdata = {IO_WINDOW_BASE, 20'h00000} | ptcd_pkg::IO_SPACE_INDICATOR;
        end else if (is_lat_reg(cap.addr)) begin
            cfg_rdata = {ptcd_pkg::BUS_LATENCY_WISH_VALUE, 24'h000000};
        end
    end

    assign cfg_hit = cap.idsel && is_cfg_cmd(cap.cmd);
    assign io_hit = is_io_cmd(cap.cmd) && (cap.addr[31:20] == IO_WINDOW_BASE);

    // ------------------------------------------------------------
    // target sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_cap = cap;
        next_is_read = is_read;
        next_is_ext = is_ext;
        next_loc_busy = loc_busy;
        next_ad_out = AD_OUT;
        next_loc_addr = LOC_ADDR;
        next_loc_wdata = LOC_WDATA;
        next_loc_rd = 1'b0;
        next_loc_wr = 1'b0;
        next_base = IO_WINDOW_BASE;
        dma_wr = '0;
        if (loc_busy && LOC_ACK) begin
            next_loc_busy = 1'b0;
        end
        case (state)
            ptcd_pkg::ST_IDLE: begin
                if (!frame_s && frame_prev) begin
                    next_cap = '{addr: ad_s, cmd: cbe_s, idsel: idsel_s};
                    next_state = ptcd_pkg::ST_CLAIM;
                end
            end
            ptcd_pkg::ST_CLAIM: begin
                next_is_read = !cap.cmd[0];
                next_is_ext = io_hit && cap.addr[ptcd_pkg::WINDOW_HALF_BIT];
                next_loc_addr = cap.addr[18:2];
                if (cfg_hit) begin
                    next_ad_out = cfg_rdata;
                    next_state = ptcd_pkg::ST_DEVSEL;
                end else if (io_hit) begin
                    next_ad_out = dma_rdata;
                    next_state = ptcd_pkg::ST_DEVSEL;
                end else begin
                    next_state = ptcd_pkg::ST_IDLE;
                end
            end
            ptcd_pkg::ST_DEVSEL: begin
                if (!(is_ext && loc_busy)) begin
                    next_state = ptcd_pkg::ST_WAIT;
                    next_loc_rd = is_ext && is_read;
                end
            end
            ptcd_pkg::ST_WAIT: begin
                if (!is_ext) begin
                    next_state = ptcd_pkg::ST_DATA;
                end else if (!is_read || LOC_ACK) begin
                    next_ad_out = is_read ? LOC_RDATA : AD_OUT;
                    next_state = ptcd_pkg::ST_DATA;
                end
            end
            ptcd_pkg::ST_DATA: begin
                if (!irdy_s) begin
                    next_state = ptcd_pkg::ST_PARK;
                    if (!is_read) begin
                        if (is_cfg_cmd(cap.cmd)) begin
                            if (is_base_reg(cap.addr)) begin
                                next_base = ad_s[31:ptcd_pkg::BASE_LSB];
                            end
                        end else if (is_ext) begin
                            next_loc_wr = 1'b1;
                            next_loc_wdata = ad_s;
                            next_loc_busy = 1'b1;
                        end else begin
                            dma_wr = '{we: 1'b1, offset: cap.addr[19:0], data: ad_s};
                        end
                    end
                end
            end
            ptcd_pkg::ST_PARK: begin
                next_state = ptcd_pkg::ST_IDLE;
            end
            default: begin
                next_state = ptcd_pkg::ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // pin drive decode
    // ------------------------------------------------------------
    always_comb begin
        next_devsel_n = !selects(next_state);
        next_trdy_n = (next_state != ptcd_pkg::ST_DATA);
        next_stop_n = (next_state != ptcd_pkg::ST_DATA);
        next_tar_oe = selects(next_state) || (next_state == ptcd_pkg::ST_PARK);
        next_ad_oe = 4'h0;
        if (next_is_read && !next_devsel_n) begin
            next_ad_oe = 4'hf;
        end
    end

    // ------------------------------------------------------------
    // sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state <= ptcd_pkg::ST_IDLE;
            cap <= '0;
            frame_prev <= 1'b1;
            is_read <= 1'b0;
            is_ext <= 1'b0;
        end else begin
            state <= next_state;
            cap <= next_cap;
            frame_prev <= frame_s;
            is_read <= next_is_read;
            is_ext <= next_is_ext;
        end
    end

    // ------------------------------------------------------------
    // pin registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            AD_OUT <= 32'h0000_0000;
            AD_OE <= 4'h0;
            DEVSEL_N <= 1'b1;
            TRDY_N <= 1'b1;
            STOP_N <= 1'b1;
            TAR_OE <= 1'b0;
        end else begin
            AD_OUT <= next_ad_out;
            AD_OE <= next_ad_oe;
            DEVSEL_N <= next_devsel_n;
            TRDY_N <= next_trdy_n;
            STOP_N <= next_stop_n;
            TAR_OE <= next_tar_oe;
        end
    end

    // ------------------------------------------------------------
    // local side registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            loc_busy <= 1'b0;
            LOC_ADDR <= 17'h00000;
            LOC_WDATA <= 32'h0000_0000;
            LOC_RD <= 1'b0;
            LOC_WR <= 1'b0;
        end else begin
            loc_busy <= next_loc_busy;
            LOC_ADDR <= next_loc_addr;
            LOC_WDATA <= next_loc_wdata;
            LOC_RD <= next_loc_rd;
            LOC_WR <= next_loc_wr;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            IO_WINDOW_BASE <= ptcd_pkg::IO_WINDOW_BASE_RESET;
        end else begin
            IO_WINDOW_BASE <= next_base;
        end
    end

endmodule

// ### ptcd_pkg.sv
package ptcd_pkg;

    // ------------------------------------------------------------
    // bus commands
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_IO_READ = 4'h2;
    localparam logic [3:0] CMD_IO_WRITE = 4'h3;
    localparam logic [3:0] CMD_CFG_READ = 4'ha;
    localparam logic [3:0] CMD_CFG_WRITE = 4'hb;

    // ------------------------------------------------------------
    // configuration space
    // ------------------------------------------------------------
    localparam logic [7:0] CFG_IO_WINDOW_BASE = 8'h14;
    localparam logic [7:0] CFG_BUS_LATENCY_WISH = 8'h3f;
    localparam logic [7:0] BUS_LATENCY_WISH_VALUE = 8'h00;
    localparam logic [11:0] IO_WINDOW_BASE_RESET = 12'h000;
    localparam int BASE_LSB = 20;
    localparam int LAT_LSB = 24;
    localparam logic [31:0] IO_SPACE_INDICATOR = 32'h0000_0001;

    // ------------------------------------------------------------
    // io window layout
    // ------------------------------------------------------------
    localparam int WINDOW_HALF_BIT = 19;
    localparam logic [19:0] OFS_TRANSFER_COUNT_CONTROL_STATUS = 20'h00000;
    localparam logic [19:0] OFS_COMMAND_ENABLE_SELECT = 20'h00004;
    localparam logic [19:0] OFS_TRANSFER_ADDRESS_COUNTER = 20'h00008;
    localparam logic [31:0] DMA_REG_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] addr;
        logic [3:0] cmd;
        logic idsel;
    } ptcd_addr_t;

    typedef struct packed {
        logic we;
        logic [19:0] offset;
        logic [31:0] data;
    } ptcd_dma_wr_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CLAIM,
        ST_DEVSEL,
        ST_WAIT,
        ST_DATA,
        ST_PARK
    } ptcd_state_t;

endpackage

// ### ptcd_dma_regs.sv
`timescale 1ns/1ps

module ptcd_dma_regs (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // write port
    input ptcd_pkg::ptcd_dma_wr_t wr,
    // read port
    input wire logic [19:0] rd_offset,
    output logic [31:0] rd_data,
    // register contents
    output logic [31:0] tccs,
    output logic [31:0] cesr,
    output logic [31:0] acr
);

    // ------------------------------------------------------------
    // offset decode
    // ------------------------------------------------------------
    function automatic logic [1:0] reg_index(input logic [19:0] ofs);
        logic [1:0] idx;
        idx = 2'h3;
        if (ofs == ptcd_pkg::OFS_TRANSFER_COUNT_CONTROL_STATUS) begin
            idx = 2'h0;
        end else if (ofs == ptcd_pkg::OFS_COMMAND_ENABLE_SELECT) begin
            idx = 2'h1;
        end else if (ofs == ptcd_pkg::OFS_TRANSFER_ADDRESS_COUNTER) begin
            idx = 2'h2;
        end
        return idx;
    endfunction

    logic [31:0] next_tccs;
    logic [31:0] next_cesr;
    logic [31:0] next_acr;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    always_comb begin
        next_tccs = tccs;
        next_cesr = cesr;
        next_acr = acr;
        if (wr.we) begin
            case (reg_index(wr.offset))
                2'h0: next_tccs = wr.data;
                2'h1: next_cesr = wr.data;
                2'h2: next_acr = wr.data;
                default: next_acr = acr;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tccs <= ptcd_pkg::DMA_REG_RESET;
            cesr <= ptcd_pkg::DMA_REG_RESET;
            acr <= ptcd_pkg::DMA_REG_RESET;
        end else begin
            tccs <= next_tccs;
            cesr <= next_cesr;
            acr <= next_acr;
        end
    end

    always_comb begin
        case (reg_index(rd_offset))
            2'h0: rd_data = tccs;
            2'h1: rd_data = cesr;
            2'h2: rd_data = acr;
            default: rd_data = 32'h0000_0000;
        endcase
    end

endmodule

// ### ptcd_target_checker.sv
`timescale 1ns/1ps

module ptcd_target_checker (
    // clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // bus
    input wire logic FRAME_N,
    input wire logic IDSEL,
    input wire logic [3:0] CBE_N,
    input wire logic [3:0] AD_OE,
    input wire logic DEVSEL_N,
    input wire logic TRDY_N,
    input wire logic STOP_N,
    input wire logic TAR_OE,
    // local side
    input wire logic LOC_RD,
    input wire logic LOC_ACK
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);
    // ----
    // target handshake
    // ----
    AST_CLAIM_CFG: assert property (
        $fell(FRAME_N) && IDSEL && CBE_N[3:1] == 3'h5 |-> ##[3:6] !DEVSEL_N)
        else $error("config cycle not claimed");
    AST_NO_CLAIM: assert property (
        $fell(FRAME_N) && !IDSEL && CBE_N[3:1] == 3'h5 |-> DEVSEL_N [*8])
        else $error("claim without select input");
    AST_TRDY_GAP: assert property (
        $fell(TRDY_N) |-> $past(DEVSEL_N, 2) == 1'b0)
        else $error("target ready too early");
    AST_STOP_WITH_TRDY: assert property (
        $fell(TRDY_N) |-> $fell(STOP_N))
        else $error("stop not with target ready");
    AST_PARK: assert property (
        $rose(DEVSEL_N) |-> TRDY_N && STOP_N && TAR_OE ##1 !TAR_OE)
        else $error("controls not parked high for one cycle");
    AST_DRIVE_OE: assert property (
        !DEVSEL_N |-> TAR_OE)
        else $error("device select without drive enable");
    AST_AD_OE_FULL: assert property (
        AD_OE != 4'h0 |-> AD_OE == 4'hf && !DEVSEL_N)
        else $error("data drivers enabled outside claim");
    AST_EXT_ACK: assert property (
        LOC_ACK && !DEVSEL_N && TRDY_N && AD_OE == 4'hf |=> !TRDY_N)
        else $error("local read ack not followed by ready");
    AST_LOC_RD_PULSE: assert property (
        LOC_RD |=> !LOC_RD)
        else $error("local read longer than one cycle");
endmodule

// ### ptcd_master_model.sv
`timescale 1ns/1ps

module ptcd_master_model (
    // clock
    input wire logic clk,
    // driven by the master
    output logic frame_n,
    output logic irdy_n,
    output logic idsel,
    output logic [31:0] ad_drv,
    output logic [3:0] cbe_n,
    // seen on the bus
    input wire logic [31:0] ad_bus,
    input wire logic [3:0] ad_oe,
    input wire logic devsel_n,
    input wire logic trdy_n,
    input wire logic stop_n
);
    initial begin
        frame_n = 1'b1;
        irdy_n = 1'b1;
        idsel = 1'b0;
        ad_drv = 32'h0;
        cbe_n = 4'h0;
    end
    // one single-phase transfer, master abort after bound cycles
    task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr, input logic sel,
        input logic [31:0] wd, input int bound, output logic [31:0] rd, output bit ok,
        output int gap, output bit drove);
        int dv;
        bit stopped;
        stopped = 0;
        ok = 0;
        gap = -1;
        dv = -1;
        drove = 0;
        rd = 32'h0;
        @(posedge clk) #1;
        frame_n = 1'b0;
        idsel = sel;
        cbe_n = cmd;
        ad_drv = addr;
        @(posedge clk) #1;
        frame_n = 1'b1;
        irdy_n = 1'b0;
        idsel = 1'b0;
        cbe_n = 4'h0;
        ad_drv = cmd[0] ? wd : ~addr;
        for (int n = 0; n < bound && !stopped; n++) begin
            @(posedge clk);
            if (ad_oe != 4'h0) drove = 1;
            if (devsel_n === 1'b0 && dv < 0) dv = n;
            if (trdy_n === 1'b0 && !ok) begin
                ok = 1;
                rd = ad_bus;
                gap = n - dv;
            end
            if (stop_n === 1'b0) stopped = 1;
        end
        #1;
        irdy_n = 1'b1;
        ad_drv = ~ad_drv;
        repeat (6) @(posedge clk);
    endtask
endmodule

// ### ptcd_target_test.sv
`timescale 1ns/1ps

module ptcd_target_test;
    logic clk = 1'b0, nrst = 1'b0, frame_n, irdy_n, idsel, devsel_n, trdy_n, stop_n;
    logic tar_oe, loc_rd, loc_wr, loc_ack = 1'b0;
    logic [31:0] m_ad, ad_bus, ad_out, loc_wdata, loc_rdata = 32'h0, tccs, cesr, acr;
    logic [3:0] cbe_n, ad_oe;
    logic [16:0] loc_addr, raddr;
    logic [11:0] io_base, base_m;
    logic [31:0] dma_m [3], lmem [int], lexp [int];
    int err_count = 0, n_tests = 0, pend = 0;
    assign ad_bus = (ad_oe == 4'hf) ? ad_out : m_ad;
    always #50 clk = ~clk;
    ptcd_target ptcd_target_i (.CLK(clk), .NRST(nrst), .FRAME_N(frame_n), .IRDY_N(irdy_n),
        .IDSEL(idsel), .AD_IN(ad_bus), .CBE_N(cbe_n), .AD_OUT(ad_out), .AD_OE(ad_oe),
        .DEVSEL_N(devsel_n), .TRDY_N(trdy_n), .STOP_N(stop_n), .TAR_OE(tar_oe),
        .LOC_ADDR(loc_addr), .LOC_WDATA(loc_wdata), .LOC_RD(loc_rd), .LOC_WR(loc_wr),
        .LOC_RDATA(loc_rdata), .LOC_ACK(loc_ack), .IO_WINDOW_BASE(io_base),
        .TRANSFER_COUNT_CONTROL_STATUS(tccs), .COMMAND_ENABLE_SELECT(cesr),
        .TRANSFER_ADDRESS_COUNTER(acr));
    ptcd_master_model ptcd_master_model_i (.clk(clk), .frame_n(frame_n), .irdy_n(irdy_n),
        .idsel(idsel), .ad_drv(m_ad), .cbe_n(cbe_n), .ad_bus(ad_bus), .ad_oe(ad_oe),
        .devsel_n(tar_oe ? devsel_n : 1'b1), .trdy_n(tar_oe ? trdy_n : 1'b1),
        .stop_n(tar_oe ? stop_n : 1'b1));
    // ----
    // local side responder
    // ----
    always @(posedge clk) begin
        #1;
        loc_ack = (pend == 1);
        loc_rdata = (pend != 1) ? ~loc_rdata : lmem.exists(raddr) ? lmem[raddr] : 32'h0;
        if (pend > 0) begin
            pend--;
        end else if (loc_rd || loc_wr) begin
            pend = 1 + $urandom_range(2);
            raddr = loc_addr;
            if (loc_wr) lmem[loc_addr] = loc_wdata;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic acc(input logic [3:0] c, input logic [31:0] a, input logic sel,
        input logic [31:0] wd, input bit claim, input logic [31:0] exp);
        logic [31:0] rd;
        bit ok, drove;
        int gap;
        ptcd_master_model_i.xfer(c, a, sel, wd, claim ? 40 : 12, rd, ok, gap, drove);
        check(32'(ok), 32'(claim));
        if (claim && !c[0]) check(rd, exp);
        if (claim) check(32'(drove), 32'(!c[0]));
        if (claim && !(a[19] && c == 4'h2)) check(32'(gap), 32'd2);
    endtask
    function automatic logic [31:0] io_exp(input logic [19:0] o);
        if (o[19]) return lexp[o[18:2]];
        if (o[19:2] < 18'd3) return dma_m[o[3:2]];
        return 32'h0;
    endfunction
    initial begin
        #(100ns * 60000);
        err_count++;
        final_report;
    end
    initial begin
        logic [31:0] d;
        logic [19:0] o;
        logic [19:0] q [$];
        void'($urandom(24));
        base_m = 12'h0;
        dma_m = '{default: 32'h0};
        repeat (5) @(posedge clk);
        #1 nrst = 1'b1;
        acc(4'hb, 32'h3c, 1, 32'hffff_ffff, 1, 0);
        acc(4'ha, 32'h3c, 1, 0, 1, {ptcd_pkg::BUS_LATENCY_WISH_VALUE, 24'h0});
        acc(4'ha, 32'h14, 1, 0, 1, ptcd_pkg::IO_SPACE_INDICATOR);
        acc(4'hb, 32'h14, 0, 32'hfff0_0000, 0, 0);
        acc(4'h6, 32'h14, 1, 32'hfff0_0000, 0, 0);
        d = $urandom;
        acc(4'hb, 32'h14, 1, d, 1, 0);
        base_m = d[31:20];
        acc(4'ha, 32'h14, 1, 0, 1, {base_m, 20'h1});
        check(32'(io_base), 32'(base_m));
        for (int i = 0; i < 10; i++) begin
            o = (i % 5 < 4) ? 20'((i % 5) * 4) : 20'h7fffc;
            d = $urandom;
            if (i < 5) acc(4'h3, {base_m, o}, 0, d, 1, 0);
            else acc(4'h2, {base_m, o}, 0, 0, 1, io_exp(o));
            if (i < 3) dma_m[i] = d;
        end
        check(tccs, dma_m[0]);
        check(cesr, dma_m[1]);
        check(acr, dma_m[2]);
        acc(4'h2, {~base_m, 20'h0}, 0, 0, 0, 0);
        for (int i = 0; i < 4; i++) begin
            o = {1'b1, 17'($urandom), 2'h0};
            d = $urandom;
            q.push_back(o);
            lexp[o[18:2]] = d;
            acc(4'h3, {base_m, o}, 0, d, 1, 0);
        end
        foreach (q[i]) acc(4'h2, {base_m, q[i]}, 0, 0, 1, io_exp(q[i]));
        #1 nrst = 1'b0;
        repeat (2) @(posedge clk);
        #1 nrst = 1'b1;
        check(tccs | cesr | acr, ptcd_pkg::DMA_REG_RESET);
        check(32'(io_base), 32'(ptcd_pkg::IO_WINDOW_BASE_RESET));
        acc(4'ha, 32'h14, 1, 0, 1, ptcd_pkg::IO_SPACE_INDICATOR);
        acc(4'h2, 32'h4, 0, 0, 1, ptcd_pkg::DMA_REG_RESET);
        final_report;
    end
endmodule

bind ptcd_target ptcd_target_checker ptcd_target_checker_i (.CLK(CLK), .NRST(NRST),
    .FRAME_N(FRAME_N), .IDSEL(IDSEL), .CBE_N(CBE_N), .AD_OE(AD_OE), .DEVSEL_N(DEVSEL_N),
    .TRDY_N(TRDY_N), .STOP_N(STOP_N), .TAR_OE(TAR_OE), .LOC_RD(LOC_RD), .LOC_ACK(LOC_ACK));
